// ===== pkg/adcp_cfg.svh
`ifndef ADCP_CFG_SVH
`define ADCP_CFG_SVH

// device register indices on the link
`define ADCP_IDX_SCR 2'h0
`define ADCP_IDX_RHI 2'h1
`define ADCP_IDX_RLO 2'h2
`define ADCP_IDX_CFG 2'h3

// status_control_reg fields
`define ADCP_SCR_FLAG 7
`define ADCP_SCR_IRQ_EN 6
`define ADCP_SCR_CONT 5
`define ADCP_CHAN_OFF 5'h1F
`define ADCP_CHAN_RESET 5'h1F

// configuration register fields
`define ADCP_CFG_LONG 0
`define ADCP_CFG_MODE8 1
`define ADCP_CFG_ASYNC 2
`define ADCP_CFG_EXT 3

// timing: sample window counted in half conversion-clock cycles
`define ADCP_SYS_HZ 50000000
`define ADCP_CONVERSION_CLOCK_HZ 1000000
`define ADCP_HALF_DIV (`ADCP_SYS_HZ / (2 * `ADCP_CONVERSION_CLOCK_HZ))
`define ADCP_SHORT_HALVES 7
`define ADCP_LONG_HALVES 47
`define ADCP_RES_BITS 10

// host APB register offsets
`define ADCP_OFS_LINK 32'h0000_0000
`define ADCP_OFS_MODE 32'h0000_0004
`define ADCP_OFS_STAT 32'h0000_0008
`define ADCP_LINK_RD_BIT 16
`define ADCP_MODE_WAIT 0
`define ADCP_MODE_STOP 1
`define ADCP_MODE_TRIG 2

`endif

// ===== pkg/adcp_pkg.sv
package adcp_pkg;
  typedef enum logic [1:0] {
    ADCP_IDLE = 2'h0,
    ADCP_SAMPLE = 2'h1,
    ADCP_CONVERT = 2'h3
  } adcp_state_e;

  typedef enum logic [1:0] {
    ADCP_H_IDLE = 2'h0,
    ADCP_H_STROBE = 2'h1,
    ADCP_H_CAPT = 2'h3
  } adcp_hstate_e;

  typedef logic [9:0] adcp_code_t;
endpackage

// ===== pkg/adcp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcp_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic irq;
  logic low_power;
  logic wait_mode;
  logic stop_mode;
  logic ext_trigger;

  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata, wait_mode, stop_mode, ext_trigger,
    output reg_rdata, irq, low_power
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, wait_mode, stop_mode, ext_trigger,
    input reg_rdata, irq, low_power
  );
endinterface
`default_nettype wire

// ===== hdl/adcp_device.sv
// Chosen here: the address map and the APB interface to the registers.
`include "adcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module adcp_device import adcp_pkg::*; (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // processor side
  adcp_link_if.dev link,
  // analog front end, already digitised level
  input wire logic [9:0] analog_level_i
);

  function automatic adcp_code_t onehot(input logic [3:0] idx);
    onehot = adcp_code_t'(10'h001 << idx);
  endfunction

  function automatic logic [7:0] round8(input adcp_code_t v);
    round8 = (v[9:2] == 8'hFF) ? 8'hFF : v[9:2] + {7'h00, v[1]};
  endfunction

  adcp_state_e state_q;
  adcp_state_e next_state;
  logic [4:0] div_cnt;
  logic [5:0] phase_cnt;
  logic [3:0] bit_idx;
  adcp_code_t sar;
  adcp_code_t sample_val;
  adcp_code_t level_meta;
  adcp_code_t level_sync;
  adcp_code_t result;
  logic irq_en;
  logic cont;
  logic [4:0] channel;
  logic flag;
  logic long_sample_select;
  logic mode8;
  logic async_clock_enable;
  logic external_convert_mode;
  logic hi_pending;
  logic [7:0] rdata_q;
  logic irq_q;
  logic low_power_q;

  wire scr_wr = link.reg_wr && (link.reg_addr == `ADCP_IDX_SCR);
  wire cfg_wr = link.reg_wr && (link.reg_addr == `ADCP_IDX_CFG);
  wire low_rd = link.reg_rd && (link.reg_addr == `ADCP_IDX_RLO);
  wire high_rd = link.reg_rd && (link.reg_addr == `ADCP_IDX_RHI);
  // only stop with the async clock off stops the converter; wait mode never does
  wire clk_gated = link.stop_mode && !async_clock_enable;
  wire chan_on = (channel != `ADCP_CHAN_OFF);
  wire sw_start = scr_wr && (link.reg_wdata[4:0] != `ADCP_CHAN_OFF)
                  && !external_convert_mode;
  wire hw_start = link.ext_trigger && external_convert_mode && chan_on
                  && (state_q == ADCP_IDLE) && !clk_gated;
  wire half_tick = (div_cnt == 5'(`ADCP_HALF_DIV - 1));
  wire [5:0] sample_last = long_sample_select ? 6'(`ADCP_LONG_HALVES - 1)
                                              : 6'(`ADCP_SHORT_HALVES - 1);
  wire sample_end = (state_q == ADCP_SAMPLE) && half_tick && (phase_cnt == sample_last);
  wire bit_step = (state_q == ADCP_CONVERT) && half_tick && (phase_cnt == 6'h01);
  wire done_evt = bit_step && (bit_idx == 4'h0);
  // a half-read 10-bit result must not be torn; the new one is dropped and redone
  wire blocked = done_evt && hi_pending && !mode8;
  wire xfer = done_evt && !blocked;
  wire restart = done_evt && (blocked || (cont && chan_on));
  // a control or config write in the completion cycle overrides the automatic restart
  wire launch = !clk_gated && (sw_start || hw_start || (restart && !scr_wr && !cfg_wr));
  wire [9:0] trial = sar | onehot(bit_idx);
  wire [9:0] decided = (sample_val >= trial) ? trial : sar;
  wire [9:0] final_code = mode8 ? {2'b00, round8(decided)} : decided;
  wire next_irq_en = scr_wr ? link.reg_wdata[`ADCP_SCR_IRQ_EN] : irq_en;
  // a completion in the same cycle as a clearing access still sets the flag
  wire next_flag = xfer || (flag && !(scr_wr || low_rd));

  always_comb begin
    next_state = state_q;
    if (clk_gated) begin
      next_state = ADCP_IDLE;
    end else if (launch) begin
      next_state = ADCP_SAMPLE;
    end else if (scr_wr || cfg_wr) begin
      next_state = ADCP_IDLE;
    end else if (sample_end) begin
      next_state = ADCP_CONVERT;
    end else if (done_evt) begin
      next_state = ADCP_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ADCP_IDLE;
      low_power_q <= 1'b1;
    end else begin
      state_q <= next_state;
      low_power_q <= (next_state == ADCP_IDLE);
    end
  end

  // conversion-clock divider and sequencing run only while sampling or converting
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= 5'h00;
      phase_cnt <= 6'h00;
    end else if (launch || next_state == ADCP_IDLE) begin
      div_cnt <= 5'h00;
      phase_cnt <= 6'h00;
    end else if (half_tick) begin
      div_cnt <= 5'h00;
      if (sample_end || bit_step) begin
        phase_cnt <= 6'h00;
      end else begin
        phase_cnt <= phase_cnt + 6'h01;
      end
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // two flops on the outside level; it must stay steady through the sample window,
  // since a word that moves while caught may be torn between old and new bits
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_meta <= 10'h000;
      level_sync <= 10'h000;
    end else begin
      level_meta <= analog_level_i;
      level_sync <= level_meta;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_idx <= 4'h0;
      sar <= 10'h000;
      sample_val <= 10'h000;
    end else if (sample_end) begin
      bit_idx <= 4'(`ADCP_RES_BITS - 1);
      sar <= 10'h000;
      sample_val <= level_sync;
    end else if (bit_step) begin
      bit_idx <= bit_idx - 4'h1;
      sar <= decided;
    end
  end

  // results change only on a finished transfer, never on an abort
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result <= 10'h000;
    end else if (xfer) begin
      result <= final_code;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_en <= 1'b0;
      cont <= 1'b0;
      channel <= `ADCP_CHAN_RESET;
    end else if (scr_wr) begin
      irq_en <= link.reg_wdata[`ADCP_SCR_IRQ_EN];
      cont <= link.reg_wdata[`ADCP_SCR_CONT];
      channel <= link.reg_wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      long_sample_select <= 1'b0;
      mode8 <= 1'b0;
      async_clock_enable <= 1'b0;
      external_convert_mode <= 1'b0;
    end else if (cfg_wr) begin
      long_sample_select <= link.reg_wdata[`ADCP_CFG_LONG];
      mode8 <= link.reg_wdata[`ADCP_CFG_MODE8];
      async_clock_enable <= link.reg_wdata[`ADCP_CFG_ASYNC];
      external_convert_mode <= link.reg_wdata[`ADCP_CFG_EXT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag <= 1'b0;
      irq_q <= 1'b0;
      hi_pending <= 1'b0;
    end else begin
      flag <= next_flag;
      irq_q <= next_flag && next_irq_en;
      hi_pending <= (high_rd && !mode8) || (hi_pending && !(low_rd || scr_wr));
    end
  end

  wire [7:0] scr_view = {flag, irq_en, cont, channel};
  wire [7:0] cfg_view = {4'h0, external_convert_mode, async_clock_enable,
                         mode8, long_sample_select};
  wire [7:0] hi_view = mode8 ? 8'h00 : {6'h00, result[9:8]};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else if (link.reg_rd) begin
      unique case (link.reg_addr)
        `ADCP_IDX_SCR: rdata_q <= scr_view;
        `ADCP_IDX_RHI: rdata_q <= hi_view;
        `ADCP_IDX_RLO: rdata_q <= result[7:0];
        `ADCP_IDX_CFG: rdata_q <= cfg_view;
      endcase
    end
  end

  assign link.reg_rdata = rdata_q;
  assign link.irq = irq_q;
  assign link.low_power = low_power_q;

endmodule
`default_nettype wire

// ===== hdl/adcp_host.sv
`include "adcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module adcp_host import adcp_pkg::*; (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // converter side
  adcp_link_if.host link
);

  adcp_hstate_e hstate;
  logic reg_wr_q;
  logic reg_rd_q;
  logic [1:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] last_rd;
  logic wait_q;
  logic stop_q;
  logic trig_q;

  wire access = psel_i && penable_i && !pready_o;
  wire sel_link = (paddr_i == `ADCP_OFS_LINK);
  wire sel_mode = (paddr_i == `ADCP_OFS_MODE);
  wire sel_stat = (paddr_i == `ADCP_OFS_STAT);
  wire start_link = access && sel_link && pwrite_i && (hstate == ADCP_H_IDLE);
  wire local_acc = access && !(sel_link && pwrite_i);
  wire is_rd = pwdata_i[`ADCP_LINK_RD_BIT];
  wire [31:0] mode_view = {29'h0, 1'b0, stop_q, wait_q};
  wire [31:0] stat_view = {30'h0, link.low_power, link.irq};
  wire [31:0] link_view = {24'h0, last_rd};
  wire [31:0] rd_mux = sel_link ? link_view : sel_mode ? mode_view :
                       sel_stat ? stat_view : 32'h0000_0000;

  // a link access: strobe one cycle, then the device answers one cycle later
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hstate <= ADCP_H_IDLE;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      addr_q <= 2'h0;
      wdata_q <= 8'h00;
      last_rd <= 8'h00;
    end else begin
      unique case (hstate)
        ADCP_H_IDLE: begin
          if (start_link) begin
            hstate <= ADCP_H_STROBE;
            reg_wr_q <= !is_rd;
            reg_rd_q <= is_rd;
            addr_q <= pwdata_i[9:8];
            wdata_q <= pwdata_i[7:0];
          end
        end
        ADCP_H_STROBE: begin
          hstate <= ADCP_H_CAPT;
          reg_wr_q <= 1'b0;
          reg_rd_q <= 1'b0;
        end
        ADCP_H_CAPT: begin
          hstate <= ADCP_H_IDLE;
          last_rd <= link.reg_rdata;
        end
      endcase
    end
  end

  // software decides wait and stop entry; clearing continuous first is its job
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b0;
      stop_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (local_acc && pwrite_i && sel_mode) begin
        wait_q <= pwdata_i[`ADCP_MODE_WAIT];
        stop_q <= pwdata_i[`ADCP_MODE_STOP];
        trig_q <= pwdata_i[`ADCP_MODE_TRIG];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= local_acc || (hstate == ADCP_H_CAPT);
      pslverr_o <= local_acc && !(sel_link || sel_mode || (sel_stat && !pwrite_i));
      prdata_o <= (local_acc && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  assign link.reg_wr = reg_wr_q;
  assign link.reg_rd = reg_rd_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wdata_q;
  assign link.wait_mode = wait_q;
  assign link.stop_mode = stop_q;
  assign link.ext_trigger = trig_q;

endmodule
`default_nettype wire

// ===== testbench/adcp_props.sv
`timescale 1ns/1ps
`default_nettype none
module adcp_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // link signals
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic irq,
  input wire logic low_power,
  input wire logic stop_mode,
  input wire logic ext_trigger
);
  logic cont_q, long_q, async_q, ext_q;
  logic [4:0] chan_q;
  logic [11:0] busy;
  wire scr_wr = reg_wr && reg_addr == 2'h0;
  wire cfg_wr = reg_wr && reg_addr == 2'h3;
  // shadow of the settings that decide the expected timing
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {cont_q, long_q, async_q, ext_q} <= 4'h0;
      chan_q <= 5'h1F;
    end else begin
      if (scr_wr) {cont_q, chan_q} <= reg_wdata[5:0];
      if (cfg_wr) {ext_q, async_q, long_q} <= {reg_wdata[3:2], reg_wdata[0]};
    end
  end
  // cycles since the converter left low power or since the last control write, whichever is later
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) busy <= 12'h0;
    else if (low_power || scr_wr) busy <= 12'h0;
    else busy <= busy + 12'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_start;
    scr_wr && reg_wdata[4:0] != 5'h1F && !ext_q && !(stop_mode && !async_q);
  endsequence
  sequence s_done;
    $rose(irq);
  endsequence
  property p_start; s_start |=> !low_power; endproperty
  property p_off; scr_wr && reg_wdata[4:0] == 5'h1F |=> low_power; endproperty
  property p_hold; low_power && !scr_wr && !ext_trigger |=> low_power; endproperty
  property p_win;
    s_done and !cont_q |-> (long_q ? (busy >= 12'd1672 && busy <= 12'd1678)
      : (busy >= 12'd672 && busy <= 12'd678));
  endproperty
  property p_single; s_done and !cont_q |-> low_power; endproperty
  property p_cont; s_done and cont_q |-> !low_power; endproperty
  property p_clr; scr_wr || (reg_rd && reg_addr == 2'h2) |=> !irq; endproperty
  property p_stop; stop_mode && !async_q |=> low_power; endproperty
  property p_trig;
    ext_trigger && ext_q && async_q && stop_mode && low_power && chan_q != 5'h1F
      |=> !low_power;
  endproperty
  a_start: assert property (p_start) else $error("no start after control write");
  a_off: assert property (p_off) else $error("channel off did not idle");
  a_hold: assert property (p_hold) else $error("converter left idle by itself");
  a_win: assert property (p_win) else $error("conversion length wrong");
  a_single: assert property (p_single) else $error("no low power after single");
  a_cont: assert property (p_cont) else $error("continuous did not restart");
  a_clr: assert property (p_clr) else $error("irq not cleared");
  a_stop: assert property (p_stop) else $error("stop did not abort");
  a_trig: assert property (p_trig) else $error("trigger did not start");
endmodule
`default_nettype wire

// ===== testbench/tb_adc_conversion_power_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_power_control;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [9:0] an, p;
  logic [7:0] h, l;
  logic e;
  int exp_q[$];
  int fail_count, n_tests, seed, i;
  adcp_link_if lnk();
  adcp_device u_adcp_device(.sys_clk_i(sys_clk), .resetn_i(resetn), .link(lnk.dev),
    .analog_level_i(an));
  adcp_host u_adcp_host(.sys_clk_i(sys_clk), .resetn_i(resetn), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(lnk.host));
  adcp_props u_adcp_props(.sys_clk_i(sys_clk), .resetn_i(resetn), .reg_wr(lnk.reg_wr),
    .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .irq(lnk.irq), .low_power(lnk.low_power), .stop_mode(lnk.stop_mode),
    .ext_trigger(lnk.ext_trigger));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 50 && pready !== 1'b1; k++)
      @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    r = prdata;
    e = pslverr;
    if (k == 50) begin
      fail_count++;
      give_verdict;
    end
  endtask
  task lw(input logic [1:0] x, input logic [7:0] b);
    apb(1'b1, 32'h0, {22'h0, x, b});
  endtask
  task lr(input logic [1:0] x, output logic [7:0] b);
    apb(1'b1, 32'h0, {15'h0, 1'b1, 6'h0, x, 8'h0});
    apb(1'b0, 32'h0, 32'h0);
    b = r[7:0];
  endtask
  // polls status; the bound covers a long conversion with margin
  task wstat(input logic [31:0] m);
    int k;
    for (k = 0; k < 600; k++) begin
      apb(1'b0, 32'h8, 32'h0);
      if ((r & m) != 32'h0) return;
    end
    fail_count++;
    give_verdict;
  endtask
  // integer model: 10-bit code as sampled; 8-bit mode rounds to nearest and saturates
  function automatic int model_code(input int v, input logic m8);
    int q;
    q = (v + 2) / 4;
    if (q > 255) q = 255;
    model_code = m8 ? q : v;
  endfunction
  // high byte first, as the read pairing requires
  task res(input logic m8, input logic [9:0] v);
    exp_q.push_back(model_code(int'(v), m8));
    lr(2'h1, h);
    lr(2'h2, l);
    chk({24'h0, h}, 32'(exp_q[0] >> 8));
    chk({24'h0, l}, 32'(exp_q.pop_front() % 256));
  endtask
  initial begin
    seed = 36;
    fail_count = 0;
    n_tests = 0;
    {resetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 64'h0;
    an = 10'h0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h2);
    apb(1'b0, 32'hC, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (i = 0; i < 4; i++) begin
      an <= 10'($random(seed));
      apb(1'b1, 32'h4, 32'(i % 2));
      lw(2'h3, 8'(i));
      lw(2'h0, 8'h43);
      wstat(32'h1);
      res(i[1], an);
      apb(1'b0, 32'h8, 32'h0);
      chk(r, 32'h2);
    end
    apb(1'b0, 32'h4, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, 32'h4, 32'h0);
    lw(2'h3, 8'h0);
    lw(2'h0, 8'h03);
    wstat(32'h2);
    lr(2'h0, h);
    chk({24'h0, h}, 32'h83);
    apb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h2);
    p = an;
    an <= 10'($random(seed));
    lw(2'h0, 8'h43);
    apb(1'b1, 32'h4, 32'h2);
    apb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, 32'h4, 32'h0);
    apb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h2);
    res(1'b0, p);
    lw(2'h3, 8'h0C);
    lr(2'h3, h);
    chk({24'h0, h}, 32'hC);
    lw(2'h0, 8'h43);
    apb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h2);
    apb(1'b1, 32'h4, 32'h6);
    wstat(32'h1);
    res(1'b0, an);
    apb(1'b1, 32'h4, 32'h0);
    lw(2'h3, 8'h0);
    lw(2'h0, 8'h63);
    wstat(32'h1);
    res(1'b0, an);
    an <= 10'($random(seed));
    wstat(32'h1);
    res(1'b0, an);
    apb(1'b0, 32'h8, 32'h0);
    chk(r & 32'h2, 32'h0);
    lw(2'h0, 8'h1F);
    apb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h2);
    give_verdict;
  end
endmodule
`default_nettype wire
